// File: design/etsb_frame_pick.sv
// picks the stored bit for one frame position out of an eight-frame register
`timescale 1ns/1ps
module etsb_frame_pick #(
    parameter int WIDTH = 8,
    parameter int IW    = $clog2(WIDTH)
) (
    input  wire logic [WIDTH-1:0] frameBits,
    input  wire logic [IW-1:0]    pairIdx,
    output logic                  pickBit
);
    localparam logic [IW-1:0] TOP = IW'(WIDTH - 1);

    // first frame of the register sits in the top bit, later frames below
    assign pickBit = frameBits[TOP - pairIdx];
endmodule // etsb_frame_pick

// File: design/etsb_ovh_if.sv
// bundle between the register bank and the overhead merge logic
`timescale 1ns/1ps
interface etsb_ovh_if;
    import etsb_pkg::*;
    logic [FRAME_W-1:0] frameNum;
    logic [REG_W-1:0]   normalByte;
    logic [REG_W-1:0]   enables;
    logic [REG_W-1:0]   srcBits;
    logic [REG_W-1:0]   mergedByte;
    modport source (output frameNum, normalByte, enables, srcBits, input mergedByte);
    modport merge  (input frameNum, normalByte, enables, srcBits, output mergedByte);
endinterface

// File: design/etsb_ovh_merge.sv
// overlays enabled register bits onto the framer's timeslot zero byte
`timescale 1ns/1ps
module etsb_ovh_merge (
    etsb_ovh_if.merge ovh
);
    import etsb_pkg::*;

    // aligned frames only take the align Si; non-aligned frames take every other source
    always_comb begin
        ovh.mergedByte = ovh.normalByte;
        if (!ovh.frameNum[0]) begin
            if (ovh.enables[CTRL_INTL_ALIGN_BIT]) begin
                ovh.mergedByte[TS_INTL_POS] = ovh.srcBits[CTRL_INTL_ALIGN_BIT];
            end
        end else begin
            if (ovh.enables[CTRL_INTL_NONALIGN_BIT]) begin
                ovh.mergedByte[TS_INTL_POS] = ovh.srcBits[CTRL_INTL_NONALIGN_BIT];
            end
            ovh.mergedByte[TS_FIXED_POS] = 1'b1;
            for (int i = CTRL_SA8_BIT; i <= CTRL_ALARM_BIT; i++) begin
                if (ovh.enables[i]) begin
                    ovh.mergedByte[i] = ovh.srcBits[i];
                end
            end
        end
    end
endmodule // etsb_ovh_merge

// File: design/etsb_pkg.sv
// shared constants, types and reset state of the E1 transmit overhead insertion bank
// How it works
// - aligned-frame Si register holds even frames 0..14, bit 7 is frame 0
// - non-aligned Si register holds odd frames 1..15, bit 7 is frame 1
// - remote alarm register supplies A bit for odd frames, bit 7 frame 1
// - Sa4 register supplies odd frames 1..15, MSB frame 1, LSB frame 15
// - Sa5 register supplies odd frames 1..15, bit 7 frame 1
// - Sa6 register supplies odd frames 1..15, bit 7 frame 1
// - Sa7 register supplies odd frames 1..15, bit 6 frame 3
// - Sa8 register supplies odd frames 1..15, bit 7 frame 1
// - control register holds one insert enable per source, Si align at bit 7
// - non-aligned byte is Si, fixed one, alarm, then Sa4 to Sa8
// - enable low keeps framer value, enable high takes stored register bit
package etsb_pkg;

    //--------------------------------------------------------------------
    // bus and register geometry
    //--------------------------------------------------------------------
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam int REG_W      = 8;
    localparam int REG_COUNT  = 9;
    localparam int IDX_W      = 8;
    localparam int SLOT_W     = 4;
    localparam int FRAME_W    = 4;

    //--------------------------------------------------------------------
    // register indices; byte address is four times the index
    //--------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_TX_INTL_ALIGN    = 8'hD2;
    localparam logic [IDX_W-1:0] IDX_TX_INTL_NONALIGN = 8'hD3;
    localparam logic [IDX_W-1:0] IDX_TX_REMOTE_ALARM  = 8'hD4;
    localparam logic [IDX_W-1:0] IDX_TX_NATIONAL_BIT4 = 8'hD5;
    localparam logic [IDX_W-1:0] IDX_TX_NATIONAL_BIT5 = 8'hD6;
    localparam logic [IDX_W-1:0] IDX_TX_NATIONAL_BIT6 = 8'hD7;
    localparam logic [IDX_W-1:0] IDX_TX_NATIONAL_BIT7 = 8'hD8;
    localparam logic [IDX_W-1:0] IDX_TX_NATIONAL_BIT8 = 8'hD9;
    localparam logic [IDX_W-1:0] IDX_TX_OVH_CTRL      = 8'hDA;
    localparam logic [IDX_W-1:0] IDX_TX_OVH_STATUS    = 8'hF0;

    // storage slots inside the bank, counted from the first index
    localparam logic [SLOT_W-1:0] SLOT_INTL_ALIGN  = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_REMOTE_ALRM = 4'h2;
    localparam logic [SLOT_W-1:0] SLOT_NATL_BIT8   = 4'h7;
    localparam logic [SLOT_W-1:0] SLOT_CTRL        = 4'h8;

    localparam logic [REG_W-1:0] REG_RESET = 8'h00;

    //--------------------------------------------------------------------
    // control enable positions, also the source order of picked bits
    //--------------------------------------------------------------------
    localparam int CTRL_INTL_ALIGN_BIT    = 7;
    localparam int CTRL_INTL_NONALIGN_BIT = 6;
    localparam int CTRL_ALARM_BIT         = 5;
    localparam int CTRL_SA4_BIT           = 4;
    localparam int CTRL_SA8_BIT           = 0;

    // positions in the transmitted timeslot zero byte
    localparam int TS_INTL_POS  = 7;
    localparam int TS_FIXED_POS = 6;
    localparam int TS_ALARM_POS = 5;

    // status register fields
    localparam int STAT_FRAME_LSB   = 0;
    localparam int STAT_ALIGNED_POS = 4;

    //--------------------------------------------------------------------
    // whole state of the bank
    //--------------------------------------------------------------------
    typedef struct packed {
        logic [REG_COUNT-1:0][REG_W-1:0] regs;
        logic [APB_DATA_W-1:0]           rdata;
        logic [REG_W-1:0]                txByte;
        logic                            txValid;
        logic [FRAME_W-1:0]              lastFrame;
        logic                            lastAligned;
    } etsb_state_t;

    localparam etsb_state_t STATE_RESET = '{regs: {REG_COUNT{REG_RESET}}, default: '0};

endpackage

// File: design/etsb_tx_overhead_bank.sv
// E1 transmit overhead register bank with APB slave and timeslot zero insertion
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module etsb_tx_overhead_bank (
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [etsb_pkg::APB_ADDR_W-1:0]  paddr,
    input  wire logic [etsb_pkg::APB_DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [etsb_pkg::APB_DATA_W-1:0]  prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             tsValid,
    input  wire logic [etsb_pkg::FRAME_W-1:0]     tsFrameNum,
    input  wire logic [etsb_pkg::REG_W-1:0]       tsByte,
    output logic                                  txValid,
    output logic      [etsb_pkg::REG_W-1:0]       txByte
);
    import etsb_pkg::*;

    //--------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------
    etsb_state_t        st_reg;
    etsb_state_t        st_next;
    logic [IDX_W-1:0]   accIdx;
    logic [SLOT_W-1:0]  slot;
    logic               slotHit;
    logic               statusHit;
    logic [REG_W-1:0]   statusByte;
    logic [REG_W-1:0]   readByte;
    logic               setupRead;
    logic               accessPhase;
    logic               wrFire;
    logic [REG_W-1:0]   ctrlBits;
    logic [REG_W-1:0]   srcBits;

    etsb_ovh_if ovh ();

    //--------------------------------------------------------------------
    // apb address decode
    //--------------------------------------------------------------------

    // word index from the byte address; misaligned or high addresses miss
    assign accIdx = paddr[IDX_W+1:2];

    always_comb begin
        slotHit   = 1'b0;
        statusHit = 1'b0;
        slot      = '0;
        if (paddr[1:0] != 2'b00) begin
            slotHit = 1'b0;
        end else if (paddr[APB_ADDR_W-1:IDX_W+2] != '0) begin
            slotHit = 1'b0;
        end else if (accIdx >= IDX_TX_INTL_ALIGN && accIdx <= IDX_TX_OVH_CTRL) begin
            slotHit = 1'b1;
            slot    = SLOT_W'(accIdx - IDX_TX_INTL_ALIGN);
        end else if (accIdx == IDX_TX_OVH_STATUS) begin
            statusHit = 1'b1;
        end
    end

    //--------------------------------------------------------------------
    // apb phases and answer
    //--------------------------------------------------------------------

    // setup cycle of a read loads the read data flop
    assign setupRead   = psel && !penable && !pwrite;
    assign accessPhase = psel && penable;

    // writes land only on the access edge, low byte lane only
    assign wrFire = accessPhase && pwrite && slotHit && pstrb[0];

    // no wait states; unmapped access answers with an error
    assign pready  = 1'b1;
    assign pslverr = accessPhase && !slotHit && !statusHit;
    assign prdata  = st_reg.rdata;

    //--------------------------------------------------------------------
    // read multiplexer
    //--------------------------------------------------------------------

    // status shows the last frame position sent and its alignment
    always_comb begin
        statusByte                                  = '0;
        statusByte[STAT_FRAME_LSB +: FRAME_W]       = st_reg.lastFrame;
        statusByte[STAT_ALIGNED_POS]                = st_reg.lastAligned;
    end

    always_comb begin
        if (slotHit) begin
            readByte = st_reg.regs[slot];
        end else if (statusHit) begin
            readByte = statusByte;
        end else begin
            readByte = '0;
        end
    end

    //--------------------------------------------------------------------
    // per-frame source selection
    //--------------------------------------------------------------------

    assign ctrlBits = st_reg.regs[SLOT_CTRL];

    // one picker per source; source j lands at enable position 7-j
    for (genvar j = 0; j < REG_COUNT - 1; j++) begin : g_pick
        etsb_frame_pick #(
            .WIDTH (REG_W)
        ) u_pick (
            .frameBits (st_reg.regs[j]),
            .pairIdx   (tsFrameNum[FRAME_W-1:1]),
            .pickBit   (srcBits[REG_W-1-j])
        );
    end

    // feed the merge logic
    assign ovh.frameNum   = tsFrameNum;
    assign ovh.normalByte = tsByte;
    assign ovh.enables    = ctrlBits;
    assign ovh.srcBits    = srcBits;

    etsb_ovh_merge u_merge (
        .ovh (ovh.merge)
    );

    //--------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------

    always_comb begin
        st_next = st_reg;
        if (setupRead) begin
            st_next.rdata = {{(APB_DATA_W-REG_W){1'b0}}, readByte};
        end
        if (wrFire) begin
            st_next.regs[slot] = pwdata[REG_W-1:0];
        end
        st_next.txValid = tsValid;
        if (tsValid) begin
            st_next.txByte      = ovh.mergedByte;
            st_next.lastFrame   = tsFrameNum;
            st_next.lastAligned = !tsFrameNum[0];
        end
    end

    //--------------------------------------------------------------------
    // state register
    //--------------------------------------------------------------------

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign txValid = st_reg.txValid;
    assign txByte  = st_reg.txByte;

    //--------------------------------------------------------------------
    // checking helpers
    //--------------------------------------------------------------------

    // bit-reversed copies so frame pair k (frame number shifted right by one) reads at ascending index k
    logic [REG_W-1:0] alignRev;
    logic [REG_W-1:0] nonalignRev;
    logic [REG_W-1:0] alarmRev;
    logic [REG_W-1:0] sa7Rev;
    logic [REG_W-1:0] sa8Rev;
    logic             expAlignSi;
    logic             expNonalignSi;
    logic             expAlarm;
    logic             expSa7;
    logic             expSa8;

    assign alignRev      = {<<{st_reg.regs[SLOT_INTL_ALIGN]}};
    assign nonalignRev   = {<<{st_reg.regs[1]}};
    assign alarmRev      = {<<{st_reg.regs[SLOT_REMOTE_ALRM]}};
    assign sa7Rev        = {<<{st_reg.regs[6]}};
    assign sa8Rev        = {<<{st_reg.regs[SLOT_NATL_BIT8]}};
    assign expAlignSi    = alignRev[tsFrameNum[FRAME_W-1:1]];
    assign expNonalignSi = nonalignRev[tsFrameNum[FRAME_W-1:1]];
    assign expAlarm      = alarmRev[tsFrameNum[FRAME_W-1:1]];
    assign expSa7        = sa7Rev[tsFrameNum[FRAME_W-1:1]];
    assign expSa8        = sa8Rev[tsFrameNum[FRAME_W-1:1]];

    // register bit index of the current frame pair, top bit first
    logic [FRAME_W-2:0] pairRev;
    assign pairRev       = ~tsFrameNum[FRAME_W-1:1];

    //--------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // aligned frame with enable takes Si for frame n from the align register
    a_align_si_insert: assert property (
        tsValid && !tsFrameNum[0] && ctrlBits[CTRL_INTL_ALIGN_BIT]
        |=> txByte[TS_INTL_POS] == $past(expAlignSi))
        else $error("aligned frame Si differs from stored bit");

    // non-aligned frame with enable takes Si from the non-align register
    a_nonalign_si_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_INTL_NONALIGN_BIT]
        |=> txByte[TS_INTL_POS] == $past(expNonalignSi))
        else $error("non-aligned frame Si differs from stored bit");

    // remote alarm enabled on odd frames comes from the alarm register
    a_alarm_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_ALARM_BIT]
        |=> txByte[TS_ALARM_POS] == $past(expAlarm))
        else $error("remote alarm bit differs from stored bit");

    // Sa7 for frame 3 sits in register bit 6
    a_sa7_frame3: assert property (
        tsValid && tsFrameNum == 4'h3 && ctrlBits[CTRL_SA8_BIT + 1]
        |=> txByte[CTRL_SA8_BIT + 1] == $past(st_reg.regs[6][6]))
        else $error("Sa7 of frame 3 not from bit 6");

    // Sa8 enabled on odd frames comes from the Sa8 register
    a_sa8_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_SA8_BIT]
        |=> txByte[CTRL_SA8_BIT] == $past(expSa8))
        else $error("Sa8 bit differs from stored bit");

    // every non-aligned byte carries the fixed one
    a_nonalign_fixed_one: assert property (
        txValid && !st_reg.lastAligned |-> txByte[TS_FIXED_POS])
        else $error("non-aligned byte lost its fixed one");

    // with Si disabled the framer's bit passes untouched
    a_si_keep_normal: assert property (
        tsValid && tsFrameNum[0] && !ctrlBits[CTRL_INTL_NONALIGN_BIT]
        |=> txByte[TS_INTL_POS] == $past(tsByte[TS_INTL_POS]))
        else $error("disabled Si was overwritten");

    // aligned frame with all enables low passes the whole byte
    a_aligned_pass: assert property (
        tsValid && !tsFrameNum[0] && ctrlBits == REG_RESET
        |=> txByte == $past(tsByte) && txValid)
        else $error("aligned byte changed while insertion is off");

    // Sa7 source with enable follows frame order across the multiframe
    a_sa7_order: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_SA8_BIT + 1]
        |=> txByte[CTRL_SA8_BIT + 1] == $past(expSa7))
        else $error("Sa7 bit not in frame order");

    // a write shows up in the addressed register one edge later
    a_reg_write: assert property (
        wrFire |=> st_reg.regs[$past(slot)] == $past(pwdata[REG_W-1:0]))
        else $error("register did not take written value");

    // read data of the setup cycle is presented in the access cycle
    a_read_back: assert property (
        setupRead && slotHit ##1 accessPhase
        |-> prdata == {{(APB_DATA_W-REG_W){1'b0}}, $past(readByte)} && pready)
        else $error("read data does not match register");

    // unmapped addresses answer with an error in the access cycle
    a_unmapped_error: assert property (
        accessPhase && !slotHit && !statusHit |-> pslverr && pready)
        else $error("unmapped access not flagged");

    // Sa4 on odd frames comes from its register
    a_sa4_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_SA4_BIT]
        |=> txByte[CTRL_SA4_BIT] == $past(st_reg.regs[3][pairRev]))
        else $error("Sa4 bit wrong");

    // Sa5 on odd frames comes from its register
    a_sa5_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_SA8_BIT + 3]
        |=> txByte[CTRL_SA8_BIT + 3] == $past(st_reg.regs[4][pairRev]))
        else $error("Sa5 bit wrong");

    // Sa6 on odd frames comes from its register
    a_sa6_insert: assert property (
        tsValid && tsFrameNum[0] && ctrlBits[CTRL_SA8_BIT + 2]
        |=> txByte[CTRL_SA8_BIT + 2] == $past(st_reg.regs[5][pairRev]))
        else $error("Sa6 bit wrong");

    // a control write sets the enables
    a_ctrl_enables: assert property (
        wrFire && slot == SLOT_CTRL
        |=> ctrlBits == $past(pwdata[REG_W-1:0]))
        else $error("enables not written");

    // aligned frames keep bits 6 to 0
    a_aligned_rest: assert property (
        tsValid && !tsFrameNum[0]
        |=> txByte[TS_FIXED_POS:0] == $past(tsByte[TS_FIXED_POS:0]))
        else $error("aligned low bits changed");

    // an offered byte is sent on the next edge
    a_tx_valid_lag: assert property (
        tsValid
        |=> txValid)
        else $error("offered byte not sent");

    // without an offer nothing is sent and the byte holds
    a_tx_idle_hold: assert property (
        !tsValid
        |=> !txValid && $stable(txByte))
        else $error("idle cycle changed line");

    // a write with the low lane off changes no register
    a_strobe_skip: assert property (
        accessPhase && pwrite && slotHit && !pstrb[0]
        |=> $stable(st_reg.regs))
        else $error("unstrobed write landed");

    // an unmapped write changes no register
    a_unmapped_no_write: assert property (
        accessPhase && pwrite && !slotHit
        |=> $stable(st_reg.regs))
        else $error("unmapped write landed");

    // a write transfer leaves the read data alone
    a_write_no_load: assert property (
        psel && !penable && pwrite
        |=> $stable(prdata))
        else $error("write loaded read data");

    // status keeps the frame number of the last sent byte
    a_status_frame: assert property (
        tsValid
        |=> st_reg.lastFrame == $past(tsFrameNum))
        else $error("status frame not updated");

    // main scenarios
    c_frame15_sa8: cover property (tsValid && tsFrameNum == 4'hF && ctrlBits[CTRL_SA8_BIT]);
    c_ctrl_write: cover property (wrFire && slot == SLOT_CTRL);
    c_strobe_skip: cover property (accessPhase && pwrite && slotHit && !pstrb[0]);
    c_status_read: cover property (setupRead && statusHit ##1 accessPhase);
    c_multiframe: cover property (tsValid && tsFrameNum == 4'h0 && ctrlBits[CTRL_INTL_ALIGN_BIT]);

endmodule // etsb_tx_overhead_bank

// File: verification/etsb_line_model.sv
// far-end framer model that receives the transmitted timeslot zero bytes
`timescale 1ns/1ps
module etsb_line_model (
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    input  wire logic                        lineValid,
    input  wire logic [etsb_pkg::REG_W-1:0]  lineByte,
    output logic      [etsb_pkg::REG_W-1:0]  rxByte,
    output logic      [15:0]                 rxCount
);
    import etsb_pkg::*;

    // latch every byte offered on the line and count them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxByte  <= '0;
            rxCount <= '0;
        end else if (lineValid) begin
            rxByte  <= lineByte;
            rxCount <= rxCount + 16'h0001;
        end
    end
endmodule // etsb_line_model

// File: verification/etsb_tx_overhead_bank_bench.sv
// self-checking bench for the transmit overhead insertion bank
`timescale 1ns/1ps
module etsb_tx_overhead_bank_bench;
    import etsb_pkg::*;

    logic                  clk;
    logic                  reset_n;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
    logic [3:0]            pstrb;
    logic [APB_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  tsValid;
    logic [FRAME_W-1:0]    tsFrameNum;
    logic [REG_W-1:0]      tsByte;
    logic                  txValid;
    logic [REG_W-1:0]      txByte;
    logic [REG_W-1:0]      rxByte;
    logic [15:0]           rxCount;
    logic [REG_W-1:0]      regVal [REG_COUNT];
    logic [31:0]           rd;
    logic                  err;
    int                    failures;
    int                    num_checks;

    etsb_tx_overhead_bank dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tsValid(tsValid), .tsFrameNum(tsFrameNum), .tsByte(tsByte), .txValid(txValid), .txByte(txByte));
    etsb_line_model lineModel (.clk(clk), .reset_n(reset_n), .lineValid(txValid), .lineByte(txByte),
        .rxByte(rxByte), .rxCount(rxCount));

    //--------------------------------------------------------------------
    // shared tasks
    //--------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one APB transfer, held until pready is seen high
    task automatic apbXfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // write every bank slot from regVal
    task automatic writeAll;
        for (int i = 0; i < REG_COUNT; i++) apbXfer(1'b1, 8'(IDX_TX_INTL_ALIGN + i), regVal[i]);
    endtask

    // byte the line must carry for frame f, framer byte b
    function automatic logic [7:0] expByte(input logic [3:0] f, input logic [7:0] b);
        logic [7:0] e;
        logic [7:0] c;
        int         p;
        c = regVal[8];
        p = 7 - int'(f >> 1);
        e = b;
        if (!f[0]) begin
            e[7] = c[7] ? regVal[0][p] : b[7];
        end else begin
            e[7] = c[6] ? regVal[1][p] : b[7];
            e[6] = 1'b1;
            e[5] = c[5] ? regVal[2][p] : b[5];
            for (int j = 0; j < 5; j++) e[4-j] = c[4-j] ? regVal[3+j][p] : b[4-j];
        end
        return e;
    endfunction

    // offer one framer byte, check the merged byte and that it holds
    task automatic sendFrame(input logic [3:0] f, input logic [7:0] b);
        logic [7:0] e;
        e = expByte(f, b);
        @(posedge clk);
        tsValid    <= 1'b1;
        tsFrameNum <= f;
        tsByte     <= b;
        @(posedge clk);
        tsValid <= 1'b0;
        tsByte  <= ~b;
        #1;
        check(32'(txValid), 32'h1);
        check(32'(txByte), 32'(e));
        @(posedge clk);
        #1;
        check(32'(txValid), 32'h0);
        check(32'(txByte), 32'(e));
    endtask

    //--------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------
    task automatic test_reset_values;
        for (int i = 0; i < REG_COUNT; i++) begin
            apbXfer(1'b0, 8'(IDX_TX_INTL_ALIGN + i), 8'h00);
            check(rd, 32'h0);
        end
        check(32'(txByte), 32'h0);
        $display("test reset_values done");
    endtask

    task automatic test_read_write;
        for (int i = 0; i < REG_COUNT; i++) regVal[i] = 8'(8'h11 * (i + 1)) ^ 8'h80;
        writeAll();
        for (int i = 0; i < REG_COUNT; i++) begin
            apbXfer(1'b0, 8'(IDX_TX_INTL_ALIGN + i), 8'h00);
            check(rd, 32'(regVal[i]));
        end
        pstrb <= 4'h0;
        apbXfer(1'b1, IDX_TX_OVH_CTRL, 8'h33);
        pstrb <= 4'hF;
        apbXfer(1'b0, IDX_TX_OVH_CTRL, 8'h00);
        check(rd, 32'(regVal[8]));
        apbXfer(1'b1, 8'hE0, 8'h55);
        check(32'(err), 32'h1);
        apbXfer(1'b0, 8'hE0, 8'h00);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        $display("test read_write done");
    endtask

    task automatic test_pass_through;
        regVal = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
        writeAll();
        for (int f = 0; f < 16; f++) sendFrame(4'(f), 8'h00);
        for (int f = 0; f < 2; f++) sendFrame(4'(f), 8'hBF);
        $display("test pass_through done");
    endtask

    task automatic test_single_enable;
        for (int b = 0; b < 8; b++) begin
            regVal[8] = 8'h01 << b;
            apbXfer(1'b1, IDX_TX_OVH_CTRL, regVal[8]);
            sendFrame(4'h0, 8'h00);
            sendFrame(4'hF, 8'h00);
        end
        $display("test single_enable done");
    endtask

    task automatic test_multiframe;
        logic [15:0] startCnt;
        regVal = '{8'hA5, 8'h3C, 8'h96, 8'h5A, 8'hC3, 8'h69, 8'h0F, 8'hF0, 8'hFF};
        writeAll();
        startCnt = rxCount;
        for (int m = 0; m < 2; m++)
            for (int f = 0; f < 16; f++) sendFrame(4'(f), 8'(8'h2A ^ f));
        @(posedge clk);
        #1;
        check(32'(rxCount - startCnt), 32'd32);
        check(32'(rxByte), 32'(expByte(4'hF, 8'h25)));
        regVal[8] = 8'h5A;
        apbXfer(1'b1, IDX_TX_OVH_CTRL, regVal[8]);
        for (int f = 0; f < 16; f++) sendFrame(4'(f), 8'(8'hC3 ^ f));
        apbXfer(1'b1, IDX_TX_OVH_STATUS, 8'hFF);
        check(32'(err), 32'h0);
        apbXfer(1'b0, IDX_TX_OVH_STATUS, 8'h00);
        check(rd, 32'h0F);
        $display("test multiframe done");
    endtask

    task automatic test_mid_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        apbXfer(1'b0, IDX_TX_OVH_CTRL, 8'h00);
        check(rd, 32'h0);
        apbXfer(1'b0, IDX_TX_INTL_ALIGN, 8'h00);
        check(rd, 32'h0);
        check(32'(txValid), 32'h0);
        $display("test mid_reset done");
    endtask

    //--------------------------------------------------------------------
    // clock, reset, watchdog and main sequence
    //--------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // cut a hang short well past the expected run length
    initial begin
        #(5000 * 25);
        failures++;
        end_of_test();
    end

    initial begin
        failures = 0;
        num_checks = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        tsValid = 1'b0;
        tsFrameNum = '0;
        tsByte = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        test_reset_values();
        test_read_write();
        test_pass_through();
        test_single_enable();
        test_multiframe();
        test_mid_reset();
        end_of_test();
    end
endmodule // etsb_tx_overhead_bank_bench
